// [rtl/fcp_params.svh]
/*
  constants of the flash control and key protection block: register
  addresses, field positions, reset values, command codes, timing.
  assumes inclusion from the package and the design modules.
*/
`ifndef FCP_PARAMS_SVH
`define FCP_PARAMS_SVH

// register byte addresses
`define FCP_ADR_STATUS 32'hfffff800
`define FCP_ADR_MODE 32'hfffff804
`define FCP_ADR_CMD 32'hfffff808
`define FCP_ADR_DATA 32'hfffff80c
`define FCP_ADR_ADDR 32'hfffff810
`define FCP_ADR_PROT 32'hfffff818
`define FCP_ADR_HIDE 32'hfffff820

// reset values and the lock key half
`define FCP_STATUS_RST 16'h0020
`define FCP_MODE_RST 16'h0000
`define FCP_PROT_RST 32'h00000000
`define FCP_KEY_HALF_DEFAULT 16'hffff
`define FCP_KEY_HALF_LOCK 16'hdead

// status bits
`define FCP_ST_PASS 0
`define FCP_ST_FAIL 1
`define FCP_ST_BUSY 2
`define FCP_ST_IRQ 3

// mode bits
`define FCP_MD_ERW_EN 3
`define FCP_MD_IRQ_EN 4
`define FCP_MD_KEY_BLK 5
`define FCP_MD_KEY_EN 6

// protection fields
`define FCP_PR_JTAG_READ 31
`define FCP_PAGE_GRP_LSB 11
`define FCP_PAGE_GRP_MSB 15

// command codes
`define FCP_CMD_READ 8'h01
`define FCP_CMD_WRITE 8'h02
`define FCP_CMD_ERASE_PAGE 8'h05
`define FCP_CMD_MASS_ERASE 8'h06
`define FCP_CMD_SAVE_KEY 8'h0c

// operation time in ns and its cycle count at 100 MHz
`define FCP_CLK_PERIOD_NS 10
`define FCP_OP_TIME_NS 200
`define FCP_OP_CYCLES (`FCP_OP_TIME_NS / `FCP_CLK_PERIOD_NS)

`endif

// [rtl/fcp_pkg.sv]
/*
  types of the flash control and key protection block.
  assumes fcp_params.svh on the include path.
*/
`include "fcp_params.svh"

package fcp_pkg;

  // controller states, one-hot
  typedef enum logic [1:0] {
    FCP_IDLE = 2'h1,
    FCP_BUSY = 2'h2
  } fcp_state_type;

  typedef logic [15:0] fcp_half_type;

endpackage : fcp_pkg

// [rtl/fcp_op_timer.sv]
/*
  operation timer: runs a fixed number of cycles after a start pulse and
  flags the last one. assumes start only arrives while not running.
*/
`timescale 1ns/1ps
`include "fcp_params.svh"

module fcp_op_timer
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  output logic done
);

  logic [7:0] cnt_ff;
  logic run_ff;

  // count down; done fires in the last counted cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      run_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= 8'(`FCP_OP_CYCLES - 1);
      run_ff <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h00) begin
        run_ff <= 1'b0;
      end
    end
  end

  assign done = run_ff && (cnt_ff == 8'h00);

endmodule : fcp_op_timer

// [rtl/fcp_flash_ctrl.sv]
/*
  flash control interface with key protection: memory-mapped status, mode,
  command, data, address, persistent and volatile protection registers,
  plus the command sequencer. the flash array itself is not modelled;
  each command takes a fixed time and ends in pass or fail.
  assumes bus accesses synchronous to REF_CLK, one per cycle.
*/
// Notes on behaviour
// RULE_01: software sets protection bits for chosen pages in the persistent register.
// RULE_02: software sets mode bit 6 with bit 5 clear to enable key protection.
// RULE_03: software places the 32-bit key in the address and data registers.
// RULE_04: software issues command 0x0c, polls status for pass, then resets.
// RULE_05: changing protection repeats the whole sequence with a new protection value.
// RULE_06: key 0xdead locks protection for good; only mass erase clears it.
// RULE_07: status bit 3 set on completion with interrupt enabled; status read clears.
// RULE_08: status bit 2 shows busy, set during operations, cleared when idle.
// RULE_09: status bit 1 set on unsuccessful completion; status read clears it.
// RULE_10: status bit 0 set on successful completion; status read clears it.
// RULE_11: mode bit 4 enables the completion interrupt.
// RULE_12: mode bit 3 must be set for erase and write commands.
// RULE_13: software keeps mode bits 7:5 zero outside key entry, bit 8, 2:0 always.
// RULE_14: serial and jtag hosts use this same register interface.
// RULE_15: each protection bit covers four pages; bit 31 blocks jtag reads.
// RULE_16: saved protection applies only after save completes and a reset follows.
// RULE_17: mass erase returns the stored key to its default.
// RULE_18: blocked or protected erase and write end with fail set.
// RULE_19: pass and fail update in the same cycle busy clears.
`timescale 1ns/1ps
`include "fcp_params.svh"

module fcp_flash_ctrl
  import fcp_pkg::*;
(
  // clock and resets
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic NV_INIT,
  // register port
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [31:0] BUS_WDATA,
  output logic [31:0] BUS_RDATA,
  // access path: high when the jtag host drives the port
  input wire logic JTAG_SEL,
  // status outputs
  output logic FLASH_IRQ,
  output logic FLASH_BUSY
);

  fcp_state_type state_ff;
  logic [15:0] mode_ff;
  logic [7:0] cmd_ff;
  logic [31:0] data_ff;
  logic [15:0] addr_ff;
  logic [31:0] prot_ff;
  logic [31:0] hide_ff;
  logic [31:0] nv_prot_ff;
  fcp_half_type nv_key_hi_ff;
  fcp_half_type nv_key_lo_ff;
  logic [31:0] act_prot_ff;
  logic pass_ff;
  logic fail_ff;
  logic irq_ff;
  logic verdict_ff;
  logic save_ff;
  logic mass_ff;
  logic [31:0] rdata_ff;
  logic busy_ff;
  logic irq_out_ff;
  logic op_done;
  logic cmd_wr;
  logic sta_rd;
  logic nxt_verdict;
  logic nxt_save;
  logic nxt_mass;
  logic [31:0] eff_prot;

  // address match, used by every register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  // is the addressed 2 kB page group write protected
  function automatic logic grp_prot(input logic [31:0] p, input logic [15:0] a);
    grp_prot = p[a[`FCP_PAGE_GRP_MSB:`FCP_PAGE_GRP_LSB]];
  endfunction : grp_prot

  assign cmd_wr = BUS_WR && hit(BUS_ADDR, `FCP_ADR_CMD) && (state_ff == FCP_IDLE);
  assign sta_rd = BUS_RD && hit(BUS_ADDR, `FCP_ADR_STATUS);
  // volatile and saved protection combine
  assign eff_prot = act_prot_ff | hide_ff;

  // RULE_14 single register path
  // plain writable registers; serial and jtag hosts share them
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mode_ff <= `FCP_MODE_RST;
      data_ff <= 32'h00000000;
      addr_ff <= 16'h0000;
      prot_ff <= `FCP_PROT_RST;
      hide_ff <= `FCP_PROT_RST;
    end else if (BUS_WR) begin
      if (hit(BUS_ADDR, `FCP_ADR_MODE)) mode_ff <= BUS_WDATA[15:0];
      if (hit(BUS_ADDR, `FCP_ADR_DATA)) data_ff <= BUS_WDATA;
      if (hit(BUS_ADDR, `FCP_ADR_ADDR)) addr_ff <= BUS_WDATA[15:0];
      if (hit(BUS_ADDR, `FCP_ADR_PROT)) prot_ff <= BUS_WDATA;
      if (hit(BUS_ADDR, `FCP_ADR_HIDE)) hide_ff <= BUS_WDATA;
    end
  end

  // command register keeps the last accepted code for read back
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cmd_ff <= 8'h00;
    end else if (cmd_wr) begin
      cmd_ff <= BUS_WDATA[7:0];
    end
  end

  // verdict of a new command, decided at issue
  always_comb begin
    nxt_verdict = 1'b1;
    nxt_save = 1'b0;
    nxt_mass = 1'b0;
    case (BUS_WDATA[7:0])
      `FCP_CMD_READ: begin
        // RULE_15 jtag read block
        nxt_verdict = !(JTAG_SEL && eff_prot[`FCP_PR_JTAG_READ]);
      end
      `FCP_CMD_WRITE, `FCP_CMD_ERASE_PAGE: begin
        // RULE_12 erase write gate
        // RULE_18 refused ends failed
        nxt_verdict = mode_ff[`FCP_MD_ERW_EN] && !grp_prot(eff_prot, addr_ff);
      end
      `FCP_CMD_MASS_ERASE: begin
        // page protection does not stop it; that is the only way out of a lock
        nxt_verdict = mode_ff[`FCP_MD_ERW_EN];
        nxt_mass = mode_ff[`FCP_MD_ERW_EN];
      end
      `FCP_CMD_SAVE_KEY: begin
        // RULE_06 locked key refuses
        // a fresh part takes any key; otherwise the stored key must be given
        nxt_verdict = mode_ff[`FCP_MD_KEY_EN] && !mode_ff[`FCP_MD_KEY_BLK] &&
                      !(nv_key_hi_ff == `FCP_KEY_HALF_LOCK && nv_key_lo_ff == `FCP_KEY_HALF_LOCK) &&
                      ((nv_key_hi_ff == `FCP_KEY_HALF_DEFAULT && nv_key_lo_ff == `FCP_KEY_HALF_DEFAULT) ||
                       (nv_key_hi_ff == addr_ff && nv_key_lo_ff == data_ff[15:0]));
        nxt_save = nxt_verdict;
      end
      default: begin
        nxt_verdict = 1'b0;
      end
    endcase
  end

  // sequencer: idle until a command, busy until the timer ends
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_ff <= FCP_IDLE;
      verdict_ff <= 1'b0;
      save_ff <= 1'b0;
      mass_ff <= 1'b0;
    end else begin
      case (state_ff)
        FCP_IDLE: begin
          if (cmd_wr) begin
            state_ff <= FCP_BUSY;
            verdict_ff <= nxt_verdict;
            save_ff <= nxt_save;
            mass_ff <= nxt_mass;
          end
        end
        FCP_BUSY: begin
          if (op_done) state_ff <= FCP_IDLE;
        end
        default: begin
          state_ff <= FCP_IDLE;
        end
      endcase
    end
  end

  fcp_op_timer u_timer (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .start(cmd_wr),
    .done(op_done)
  );

  // non-volatile key and protection: the power-up init and a completed mass erase clear them
  always_ff @(posedge REF_CLK) begin
    if (NV_INIT) begin
      nv_prot_ff <= `FCP_PROT_RST;
      nv_key_hi_ff <= `FCP_KEY_HALF_DEFAULT;
      nv_key_lo_ff <= `FCP_KEY_HALF_DEFAULT;
    end else if (op_done && save_ff) begin
      nv_prot_ff <= prot_ff;
      nv_key_hi_ff <= addr_ff;
      nv_key_lo_ff <= data_ff[15:0];
    end else if (op_done && mass_ff) begin
      // RULE_17 key back to default
      nv_prot_ff <= `FCP_PROT_RST;
      nv_key_hi_ff <= `FCP_KEY_HALF_DEFAULT;
      nv_key_lo_ff <= `FCP_KEY_HALF_DEFAULT;
    end
  end

  // RULE_16 applied at reset
  // saved protection takes hold only when the system reset loads it
  always_ff @(posedge REF_CLK) begin
    if (NV_INIT) begin
      act_prot_ff <= `FCP_PROT_RST;
    end else if (SYS_RST) begin
      act_prot_ff <= nv_prot_ff;
    end
  end

  // completion flags; a completion wins over a clearing status read
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (op_done) begin
      // RULE_19 outcome with idle
      // RULE_10 pass on success
      pass_ff <= verdict_ff;
      // RULE_09 fail on failure
      fail_ff <= !verdict_ff;
      // RULE_07 interrupt status
      irq_ff <= mode_ff[`FCP_MD_IRQ_EN] | (irq_ff & !sta_rd);
    end else if (sta_rd) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
  end

  // RULE_08 busy flag
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= cmd_wr || (busy_ff && !op_done);
    end
  end

  // RULE_11 interrupt output
  // output follows the sticky bit, so a disabled interrupt never raises it
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_out_ff <= 1'b0;
    end else begin
      irq_out_ff <= (op_done && mode_ff[`FCP_MD_IRQ_EN]) || (irq_ff && !sta_rd);
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h00000000;
    end else if (BUS_RD) begin
      rdata_ff <= 32'h00000000;
      if (hit(BUS_ADDR, `FCP_ADR_STATUS)) begin
        rdata_ff[15:0] <= `FCP_STATUS_RST;
        rdata_ff[`FCP_ST_PASS] <= pass_ff;
        rdata_ff[`FCP_ST_FAIL] <= fail_ff;
        rdata_ff[`FCP_ST_BUSY] <= busy_ff;
        rdata_ff[`FCP_ST_IRQ] <= irq_ff;
      end
      if (hit(BUS_ADDR, `FCP_ADR_MODE)) rdata_ff[15:0] <= mode_ff;
      if (hit(BUS_ADDR, `FCP_ADR_CMD)) rdata_ff[7:0] <= cmd_ff;
      if (hit(BUS_ADDR, `FCP_ADR_DATA)) rdata_ff <= data_ff;
      if (hit(BUS_ADDR, `FCP_ADR_ADDR)) rdata_ff[15:0] <= addr_ff;
      if (hit(BUS_ADDR, `FCP_ADR_PROT)) rdata_ff <= prot_ff;
      if (hit(BUS_ADDR, `FCP_ADR_HIDE)) rdata_ff <= hide_ff;
    end
  end

  assign BUS_RDATA = rdata_ff;
  assign FLASH_IRQ = irq_out_ff;
  assign FLASH_BUSY = busy_ff;

endmodule : fcp_flash_ctrl

// [sim/fcp_flash_ctrl_asserts.sv]
/*
  port checker of the flash control block: busy timing, status flags.
  assumes binding onto fcp_flash_ctrl, single clock REF_CLK.
*/
`timescale 1ns/1ps
`include "fcp_params.svh"
module fcp_flash_ctrl_asserts (
  // clock and resets
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic NV_INIT,
  // register port
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic JTAG_SEL,
  // status outputs
  input wire logic FLASH_IRQ,
  input wire logic FLASH_BUSY
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  // status read strobe
  wire st_rd = BUS_RD && (BUS_ADDR == `FCP_ADR_STATUS);
  // twenty busy cycles, then idle; split so no repeat exceeds eight
  sequence s_op;
    FLASH_BUSY [*8] ##1 FLASH_BUSY [*8] ##1 FLASH_BUSY [*4] ##1 !FLASH_BUSY;
  endsequence
  property p_busy_start;
    BUS_WR && BUS_ADDR == `FCP_ADR_CMD && !FLASH_BUSY |=> FLASH_BUSY;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy did not follow command");
  property p_busy_len;
    $rose(FLASH_BUSY) |-> s_op;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_irq_rise;
    $rose(FLASH_IRQ) |-> $fell(FLASH_BUSY);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq outside completion");
  property p_irq_clr;
    st_rd && !FLASH_BUSY |=> !FLASH_IRQ;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept after status read");
  property p_rd_irq;
    st_rd |=> BUS_RDATA[3] == $past(FLASH_IRQ);
  endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("status irq bit differs from pin");
  property p_rd_busy;
    st_rd |=> BUS_RDATA[2] == $past(FLASH_BUSY);
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("status busy bit differs from pin");
  property p_rd_fixed;
    st_rd |=> BUS_RDATA[31:4] == 28'h2 && BUS_RDATA[1:0] != 2'h3;
  endproperty
  a_rd_fixed: assert property (p_rd_fixed) else $error("status fixed bits or flags wrong");
  property p_outcome;
    $fell(FLASH_BUSY) && st_rd |=> BUS_RDATA[1:0] != 2'h0;
  endproperty
  a_outcome: assert property (p_outcome) else $error("idle seen without outcome");
endmodule : fcp_flash_ctrl_asserts

// [sim/fcp_host_model.sv]
/*
  host model: software or programming host on the register port.
  assumes one-cycle strobes and read data registered one cycle later.
*/
`timescale 1ns/1ps
`include "fcp_params.svh"
module fcp_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [31:0] addr,
  output logic wr,
  output logic rd,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata
);
  // idle port at time zero
  initial begin
    addr = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 32'h0;
  end
  // one write strobe, launched after an edge
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data lands one cycle after the strobe edge
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // poll status
  // back-to-back reads, so the first idle read carries the outcome
  task automatic poll(output logic [31:0] st, output bit ok);
    ok = 1'b0;
    @(posedge clk);
    addr <= `FCP_ADR_STATUS;
    rd <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      #1;
      st = rdata;
      ok = (rdata[2] === 1'b0);
    end
    @(posedge clk);
    rd <= 1'b0;
  endtask : poll
endmodule : fcp_host_model

// [sim/tb_fcp_flash_ctrl.sv]
/*
  testbench of the flash control block: commands, protection, key lock.
  assumes the host model and checker files compiled before this one.
*/
`timescale 1ns/1ps
`include "fcp_params.svh"
module tb_fcp_flash_ctrl;
  logic ref_clk;
  logic sys_rst = 1'b1;
  logic nv_init = 1'b1;
  logic jtag_sel = 1'b0;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, rv;
  logic bus_wr, bus_rd, flash_irq, flash_busy;
  int err_total = 0;
  int checks_done = 0;
  bit ok;
  fcp_flash_ctrl dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .NV_INIT(nv_init), .BUS_ADDR(bus_addr),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .JTAG_SEL(jtag_sel),
    .FLASH_IRQ(flash_irq), .FLASH_BUSY(flash_busy));
  fcp_host_model host_u (.clk(ref_clk), .addr(bus_addr), .wr(bus_wr), .rd(bus_rd), .wdata(bus_wdata),
    .rdata(bus_rdata));
  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic sys_reset;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : sys_reset
  // mode, key halves or target, code, then the pass/fail pair
  task automatic op(input logic [15:0] md, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] c, input logic [1:0] exp);
    host_u.wr_reg(`FCP_ADR_MODE, {16'h0, md});
    host_u.wr_reg(`FCP_ADR_ADDR, {16'h0, a});
    host_u.wr_reg(`FCP_ADR_DATA, {16'h0, d});
    host_u.wr_reg(`FCP_ADR_CMD, {24'h0, c});
    host_u.poll(rv, ok);
    if (!ok) begin
      err_total++;
      close_out();
    end else begin
      chk("outcome", {30'h0, rv[1:0]}, {30'h0, exp});
    end
  endtask : op
  task automatic t_regs;
    host_u.rd_reg(`FCP_ADR_STATUS, rv);
    chk("status rst", rv, 32'h20);
    host_u.rd_reg(`FCP_ADR_MODE, rv);
    chk("mode rst", rv, 32'h0);
    host_u.wr_reg(32'hfffff8f0, 32'h5a);
    host_u.rd_reg(32'hfffff8f0, rv);
    chk("unmapped", rv, 32'h0);
    op(16'h0, 16'h0800, 16'h0, `FCP_CMD_WRITE, 2'h2);
    op(16'h0, 16'h0800, 16'h0, `FCP_CMD_ERASE_PAGE, 2'h2);
    op(16'h8, 16'h0800, 16'h0, 8'h07, 2'h2);
    op(16'h8, 16'h0800, 16'h0, `FCP_CMD_ERASE_PAGE, 2'h1);
    $display("t_regs done");
  endtask : t_regs
  // a second command during busy must be dropped
  task automatic t_irq;
    for (int m = 0; m < 2; m++) begin
      host_u.wr_reg(`FCP_ADR_MODE, m ? 32'h18 : 32'h08);
      host_u.wr_reg(`FCP_ADR_CMD, {24'h0, `FCP_CMD_WRITE});
      host_u.wr_reg(`FCP_ADR_CMD, {24'h0, `FCP_CMD_MASS_ERASE});
      repeat (21) @(posedge ref_clk);
      #1;
      chk("busy", {31'h0, flash_busy}, 32'h0);
      chk("irq pin", {31'h0, flash_irq}, {31'h0, m[0]});
      host_u.rd_reg(`FCP_ADR_STATUS, rv);
      chk("irq bit", {28'h0, rv[3:0]}, m ? 32'h9 : 32'h1);
      chk("irq clr", {31'h0, flash_irq}, 32'h0);
    end
    $display("t_irq done");
  endtask : t_irq
  task automatic t_key;
    host_u.wr_reg(`FCP_ADR_PROT, 32'h80000001);
    op(16'h40, 16'h1234, 16'h5678, `FCP_CMD_SAVE_KEY, 2'h1);
    op(16'h8, 16'h0000, 16'h0, `FCP_CMD_WRITE, 2'h1);
    sys_reset();
    op(16'h8, 16'h0700, 16'h0, `FCP_CMD_WRITE, 2'h2);
    op(16'h8, 16'h0800, 16'h0, `FCP_CMD_WRITE, 2'h1);
    @(posedge ref_clk);
    jtag_sel <= 1'b1;
    op(16'h0, 16'h0000, 16'h0, `FCP_CMD_READ, 2'h2);
    @(posedge ref_clk);
    jtag_sel <= 1'b0;
    op(16'h0, 16'h0000, 16'h0, `FCP_CMD_READ, 2'h1);
    host_u.wr_reg(`FCP_ADR_PROT, 32'h0);
    op(16'h40, 16'h1111, 16'h2222, `FCP_CMD_SAVE_KEY, 2'h2);
    op(16'h40, 16'h1234, 16'h5678, `FCP_CMD_SAVE_KEY, 2'h1);
    sys_reset();
    op(16'h8, 16'h0700, 16'h0, `FCP_CMD_WRITE, 2'h1);
    // volatile protection alone, saved protection now clear
    host_u.wr_reg(`FCP_ADR_HIDE, 32'h1);
    op(16'h8, 16'h0700, 16'h0, `FCP_CMD_WRITE, 2'h2);
    host_u.wr_reg(`FCP_ADR_HIDE, 32'h0);
    $display("t_key done");
  endtask : t_key
  task automatic t_lock;
    op(16'h8, 16'h0, 16'h0, `FCP_CMD_MASS_ERASE, 2'h1);
    host_u.wr_reg(`FCP_ADR_PROT, 32'h2);
    op(16'h40, 16'hdead, 16'hdead, `FCP_CMD_SAVE_KEY, 2'h1);
    sys_reset();
    op(16'h8, 16'h0800, 16'h0, `FCP_CMD_WRITE, 2'h2);
    host_u.wr_reg(`FCP_ADR_PROT, 32'h0);
    op(16'h40, 16'hdead, 16'hdead, `FCP_CMD_SAVE_KEY, 2'h2);
    op(16'h8, 16'h0, 16'h0, `FCP_CMD_MASS_ERASE, 2'h1);
    sys_reset();
    op(16'h8, 16'h0800, 16'h0, `FCP_CMD_WRITE, 2'h1);
    $display("t_lock done");
  endtask : t_lock
  // power-up init with reset, then the scenarios
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    nv_init <= 1'b0;
    t_regs();
    t_irq();
    t_key();
    t_lock();
    close_out();
  end
endmodule : tb_fcp_flash_ctrl
bind fcp_flash_ctrl fcp_flash_ctrl_asserts chk_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .NV_INIT(NV_INIT),
  .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
  .JTAG_SEL(JTAG_SEL), .FLASH_IRQ(FLASH_IRQ), .FLASH_BUSY(FLASH_BUSY));
